// file: hw/ufat_core.sv
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module ufat_core
  import ufat_pkg::*;
#(
  parameter int unsigned DIV_WIDTH = 8
) (
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic [ADDR_WIDTH-1:0] avsAddress,
  input  wire logic                  avsRead,
  input  wire logic                  avsWrite,
  input  wire logic [31:0]           avsWriteData,
  input  wire logic [3:0]            avsByteEnable,
  output logic      [31:0]           avsReadData,
  output logic                       avsWaitRequest,
  output logic                       serialOut,
  output logic                       serialOutEn_n,
  output logic                       serialInOwned,
  output logic                       txIrq
);

  initial begin
    if (DIV_WIDTH != 8) begin
      $error("ufat_core: divisor width must be 8");
    end
  end

  function automatic logic [8:0] ufatFrame(
    input logic [7:0] data,
    input logic       ninth,
    input logic       len9,
    input logic       parEn,
    input logic       parOdd
  );
    logic [8:0] f;
    begin
      f = {ninth & len9, data};
      if (parEn && len9) begin
        f[8] = (^data) ^ parOdd;
      end else if (parEn) begin
        f[7] = (^data[6:0]) ^ parOdd;
      end
      ufatFrame = f;
    end
  endfunction

  logic [7:0]        ctrlOne_r;
  logic [7:0]        ctrlOne_nxt;
  logic [7:0]        ctrlTwo_r;
  logic [7:0]        ctrlTwo_nxt;
  logic [7:0]        baud_r;
  logic              txEmpty_r;
  logic              txIdle_r;
  logic              clearArmed_r;
  logic              holdFull_r;
  logic [7:0]        holdData_r;
  logic [7:0]        divCnt_r;
  logic [5:0]        preCnt_r;
  ufat_tx_state_type txState_r;
  ufat_tx_state_type txState_nxt;
  logic [8:0]        shift_r;
  logic [8:0]        shift_nxt;
  logic [3:0]        bitCnt_r;
  logic [3:0]        bitCnt_nxt;
  logic              waitReq_r;
  logic [31:0]       readData_r;
  logic              serialOut_r;
  logic              serialOutEn_n_r;
  logic              serialInOwned_r;
  logic              txIrq_r;

  // Bus decode
  wire        accept    = (avsRead | avsWrite) & waitReq_r;
  wire        wrAccept  = accept & avsWrite & avsByteEnable[0];
  wire        rdAccept  = accept & avsRead;
  wire        wrCtrlOne = wrAccept & (avsAddress == ADDR_CTRL_ONE);
  wire        wrCtrlTwo = wrAccept & (avsAddress == ADDR_CTRL_TWO);
  wire        wrBaud    = wrAccept & (avsAddress == ADDR_BAUD);
  wire        wrHold    = wrAccept & (avsAddress == ADDR_TX_HOLD);
  wire        rdStatus  = rdAccept & (avsAddress == ADDR_STATUS);
  wire [7:0]  wrByte    = avsWriteData[7:0];

  wire portEn   = ctrlOne_r[C1_PORT_EN];
  wire transmit_enable     = ctrlTwo_r[C2_TX_EN];
  wire receive_enable     = ctrlTwo_r[C2_RX_EN];
  wire txActive = portEn & transmit_enable;
  wire len9     = ctrlOne_r[C1_WORD_LEN];
  wire twoStops = ctrlOne_r[C1_STOP_SEL];

  // Shared baud generator, free running
  wire       divTick = (divCnt_r == 8'h00);
  wire [5:0] preLast = ctrlTwo_r[C2_HIGH_SPD] ? PRE_HIGH_LAST : PRE_LOW_LAST;
  wire       bitTick = divTick & (preCnt_r == preLast);
  wire [7:0] divCnt_nxt = divTick ? baud_r : divCnt_r - 8'h01;
  wire [5:0] preCnt_nxt = !divTick ? preCnt_r :
                          (preCnt_r == preLast) ? 6'h00 : preCnt_r + 6'h01;

  // Holding register write is refused while it still holds data
  wire holdTaken  = wrHold & txEmpty_r;
  wire txFree     = (txState_r == TX_IDLE);
  wire directLoad = holdTaken & txActive & txFree;
  wire fromHold   = holdFull_r & txActive & txFree;
  wire loadShift  = directLoad | fromHold;
  wire [7:0] loadByte = directLoad ? wrByte : holdData_r;
  wire [8:0] frameWord = ufatFrame(loadByte, ctrlOne_r[C1_NINTH_TX], len9,
                                   ctrlOne_r[C1_PAR_EN],
                                   ctrlOne_r[C1_PAR_TYPE]);
  wire [3:0] posCount = len9 ? POS_LONG : POS_SHORT;
  wire       frameDone = (txState_r == TX_STOP) & bitTick &
                         (bitCnt_r == 4'h0);

  // Control registers; disabling the port clears the listed bits
  always_comb begin
    ctrlOne_nxt = ctrlOne_r;
    ctrlTwo_nxt = ctrlTwo_r;
    if (wrCtrlOne) begin
      ctrlOne_nxt = wrByte & C1_WMASK;
    end
    if (wrCtrlTwo) begin
      ctrlTwo_nxt = wrByte & C2_WMASK;
    end
    if (!ctrlOne_nxt[C1_PORT_EN]) begin
      ctrlOne_nxt[C1_BREAK_REQ] = 1'b0;
      ctrlTwo_nxt[C2_TX_EN]     = 1'b0;
      ctrlTwo_nxt[C2_RX_EN]     = 1'b0;
    end
  end

  // Transmit sequencer
  always_comb begin
    txState_nxt = txState_r;
    shift_nxt   = shift_r;
    bitCnt_nxt  = bitCnt_r;
    case (txState_r)
      TX_IDLE: begin
        if (loadShift) begin
          shift_nxt   = frameWord;
          txState_nxt = TX_SYNC;
        end
      end
      TX_SYNC: begin
        if (bitTick) begin
          txState_nxt = TX_START;
        end
      end
      TX_START: begin
        if (bitTick) begin
          bitCnt_nxt  = posCount - 4'h1;
          txState_nxt = TX_DATA;
        end
      end
      TX_DATA: begin
        if (bitTick) begin
          shift_nxt = {1'b0, shift_r[8:1]};
          if (bitCnt_r == 4'h0) begin
            bitCnt_nxt  = twoStops ? 4'h1 : 4'h0;
            txState_nxt = TX_STOP;
          end else begin
            bitCnt_nxt = bitCnt_r - 4'h1;
          end
        end
      end
      TX_STOP: begin
        if (bitTick) begin
          if (bitCnt_r == 4'h0) begin
            txState_nxt = TX_IDLE;
          end else begin
            bitCnt_nxt = bitCnt_r - 4'h1;
          end
        end
      end
      default: begin
        txState_nxt = TX_IDLE;
      end
    endcase
    if (!txActive) begin
      txState_nxt = TX_IDLE;
      bitCnt_nxt  = 4'h0;
    end
  end

  wire lineBit = (txState_r == TX_START) ? 1'b0 :
                 (txState_r == TX_DATA)  ? shift_r[0] : 1'b1;

  wire [7:0] statusByte = {txEmpty_r, txIdle_r, 5'h00, 1'b1};

  wire [7:0] readByte =
    (avsAddress == ADDR_CTRL_ONE) ? ctrlOne_r :
    (avsAddress == ADDR_CTRL_TWO) ? ctrlTwo_r :
    (avsAddress == ADDR_STATUS)   ? statusByte :
    (avsAddress == ADDR_BAUD)     ? baud_r : 8'h00;

  // Armed clear: a status read arms, the next holding write taken (holdTaken) consumes it
  wire armedClear = holdTaken & clearArmed_r;
  wire txIdle_nxt = !portEn ? 1'b1 :
                    frameDone ? 1'b1 :
                    armedClear ? 1'b0 : txIdle_r;
  wire txEmpty_nxt = !portEn ? 1'b1 :
                     fromHold ? 1'b1 :
                     (holdTaken && !directLoad) ? 1'b0 : txEmpty_r;
  wire holdFull_nxt = !portEn ? 1'b0 :
                      fromHold ? 1'b0 :
                      (holdTaken && !directLoad) ? 1'b1 : holdFull_r;
  wire armed_nxt = rdStatus ? 1'b1 : holdTaken ? 1'b0 : clearArmed_r;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrlOne_r <= C1_RESET;
      ctrlTwo_r <= C2_RESET;
      baud_r    <= BAUD_RESET;
    end else begin
      ctrlOne_r <= ctrlOne_nxt;
      ctrlTwo_r <= ctrlTwo_nxt;
      if (wrBaud) begin
        baud_r <= wrByte;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      txEmpty_r    <= 1'b1;
      txIdle_r     <= 1'b1;
      clearArmed_r <= 1'b0;
      holdFull_r   <= 1'b0;
      holdData_r   <= 8'h00;
    end else begin
      txEmpty_r    <= txEmpty_nxt;
      txIdle_r     <= txIdle_nxt;
      clearArmed_r <= armed_nxt;
      holdFull_r   <= holdFull_nxt;
      if (holdTaken && !directLoad) begin
        holdData_r <= wrByte;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      divCnt_r  <= 8'h00;
      preCnt_r  <= 6'h00;
      txState_r <= TX_IDLE;
      shift_r   <= 9'h000;
      bitCnt_r  <= 4'h0;
    end else begin
      divCnt_r  <= divCnt_nxt;
      preCnt_r  <= preCnt_nxt;
      txState_r <= txState_nxt;
      shift_r   <= shift_nxt;
      bitCnt_r  <= bitCnt_nxt;
    end
  end

  // One wait cycle per access keeps every bus output a flop
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      waitReq_r  <= 1'b1;
      readData_r <= 32'h0000_0000;
    end else begin
      waitReq_r <= !accept;
      if (rdAccept) begin
        readData_r <= {24'h00_0000, readByte};
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      serialOut_r     <= 1'b1;
      serialOutEn_n_r <= 1'b1;
      serialInOwned_r <= 1'b0;
      txIrq_r         <= 1'b0;
    end else begin
      serialOut_r     <= lineBit;
      serialOutEn_n_r <= !txActive;
      serialInOwned_r <= portEn & receive_enable;
      txIrq_r         <= txEmpty_r & ctrlTwo_r[C2_TX_IE];
    end
  end

  assign avsReadData    = readData_r;
  assign avsWaitRequest = waitReq_r;
  assign serialOut      = serialOut_r;
  assign serialOutEn_n  = serialOutEn_n_r;
  assign serialInOwned  = serialInOwned_r;
  assign txIrq          = txIrq_r;

endmodule

`default_nettype wire

// file: hw/ufat_pkg.sv
// What this block does
// - Frames are NRZ: one start bit, eight or nine positions, one or two stop_bit_count_select.
// - Reset format is eight data bits, no parity, one stop bit.
// - Parity is even, odd or off via enable and type bits.
// - Data positions go onto the line least significant bit first.
// - One shared format and one shared 8-bit baud divisor serve both directions.
// - With port, transmit and receive enabled, the pins become serial out and in.
// - An owned output pin idles high between frames.
// - Disabling the port frees both pins and empties the holding buffer.
// - Disable clears transmit and receive enables, break and error flags; sets idle and empty flags.
// - Disable halts transfers at once; re-enable resumes with kept configuration.
// - Parity takes the last data position; stop count is independent of length.
// - Nine-bit frames without parity take the top bit from the ninth transmit bit.
// - The shifter reloads only after the last stop bit, from pending held data.
// - Sending needs held data and baud timing; data-then-enable also starts.
// - Dropping transmit enable mid-frame aborts, resets and frees the pin.
// - Holding writes are refused while the transmit-empty flag is low.
// - Status read then holding write clears transmitter-idle; transmit-empty clears only if the write lands in the holding register.
// - Transmit-empty shows room in the holding register; enable gates an interrupt.
// - Writes during a frame wait; writes while idle start at once.
// - Transmitter-idle sets when a frame's stop bits finish.
// - Bit rate is clock over 64(N+1), or 16(N+1) in high speed.
package ufat_pkg;

  localparam int unsigned ADDR_WIDTH = 5;

  localparam logic [4:0] ADDR_CTRL_ONE = 5'h00;
  localparam logic [4:0] ADDR_CTRL_TWO = 5'h04;
  localparam logic [4:0] ADDR_STATUS   = 5'h08;
  localparam logic [4:0] ADDR_TX_HOLD  = 5'h0c;
  localparam logic [4:0] ADDR_BAUD     = 5'h10;

  // serial_control_one fields
  localparam int unsigned C1_PORT_EN   = 7;
  localparam int unsigned C1_WORD_LEN  = 6;
  localparam int unsigned C1_PAR_EN    = 5;
  localparam int unsigned C1_PAR_TYPE  = 4;
  localparam int unsigned C1_STOP_SEL  = 3;
  localparam int unsigned C1_BREAK_REQ = 2;
  localparam int unsigned C1_NINTH_TX  = 0;
  localparam logic [7:0]  C1_WMASK     = 8'hfd;
  localparam logic [7:0]  C1_RESET     = 8'h00;

  // serial_control_two fields
  localparam int unsigned C2_TX_EN     = 7;
  localparam int unsigned C2_RX_EN     = 6;
  localparam int unsigned C2_HIGH_SPD  = 5;
  localparam int unsigned C2_TX_IE     = 4;
  localparam logic [7:0]  C2_WMASK     = 8'hf0;
  localparam logic [7:0]  C2_RESET     = 8'h00;

  // serial_status_register fields
  localparam int unsigned ST_RX_IDLE   = 0;
  localparam int unsigned ST_RX_AVAIL  = 1;
  localparam int unsigned ST_NOISE     = 2;
  localparam int unsigned ST_FRAMING   = 3;
  localparam int unsigned ST_PARITY    = 4;
  localparam int unsigned ST_OVERRUN   = 5;
  localparam int unsigned ST_TX_IDLE   = 6;
  localparam int unsigned ST_TX_EMPTY  = 7;

  localparam logic [7:0]  BAUD_RESET   = 8'h00;
  localparam logic [5:0]  PRE_LOW_LAST  = 6'h3f;
  localparam logic [5:0]  PRE_HIGH_LAST = 6'h0f;
  localparam logic [3:0]  POS_SHORT    = 4'h8;
  localparam logic [3:0]  POS_LONG     = 4'h9;

  typedef enum logic [2:0] {
    TX_IDLE,
    TX_SYNC,
    TX_START,
    TX_DATA,
    TX_STOP
  } ufat_tx_state_type;

endpackage

// file: test/ufat_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ufat_core_assertions
  import ufat_pkg::*;
(
  input wire logic                  clk_sys,
  input wire logic                  sys_rst,
  input wire logic [ADDR_WIDTH-1:0] avsAddress,
  input wire logic                  avsRead,
  input wire logic                  avsWrite,
  input wire logic [31:0]           avsWriteData,
  input wire logic [3:0]            avsByteEnable,
  input wire logic [31:0]           avsReadData,
  input wire logic                  avsWaitRequest,
  input wire logic                  serialOut,
  input wire logic                  serialOutEn_n,
  input wire logic                  serialInOwned,
  input wire logic                  txIrq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [15:0] runCnt_r;
  logic        lastOut_r;
  logic        ieShadow_r;
  wire logic   wrTaken = avsWrite && avsWaitRequest && avsByteEnable[0];
  wire logic   rdDone  = avsRead && !avsWaitRequest;
  // Every bit time is a multiple of 16 clocks, so a low run must be too
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      runCnt_r   <= 16'h0;
      lastOut_r  <= 1'b1;
      ieShadow_r <= 1'b0;
    end else begin
      runCnt_r  <= (serialOut != lastOut_r) ? 16'h1 : runCnt_r + 16'h1;
      lastOut_r <= serialOut;
      if (wrTaken && avsAddress == ADDR_CTRL_TWO) begin
        ieShadow_r <= avsWriteData[C2_TX_IE];
      end
    end
  end
  a_wait_one_low: assert property (
    $fell(avsWaitRequest) |=> avsWaitRequest) else $error("long wait low");
  a_request_answered: assert property (
    (avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
    else $error("request not answered");
  a_unmapped_zero: assert property (
    rdDone && avsAddress > ADDR_BAUD |-> avsReadData == 32'h0)
    else $error("unmapped read not zero");
  a_status_fixed: assert property (
    rdDone && avsAddress == ADDR_STATUS
    |-> avsReadData[31:8] == 24'h0 && avsReadData[5:0] == 6'h01)
    else $error("status receive bits wrong");
  a_port_off_frees: assert property (
    wrTaken && avsAddress == ADDR_CTRL_ONE && !avsWriteData[C1_PORT_EN]
    |-> ##[1:3] (serialOutEn_n && !serialInOwned))
    else $error("pins kept after port off");
  a_tx_off_frees: assert property (
    wrTaken && avsAddress == ADDR_CTRL_TWO && !avsWriteData[C2_TX_EN]
    |-> ##[1:3] serialOutEn_n) else $error("pin kept after tx off");
  a_owned_idle_high: assert property (
    $fell(serialOutEn_n) |-> serialOut) else $error("line low on take");
  a_irq_needs_ie: assert property (
    txIrq |-> $past(ieShadow_r)) else $error("irq without enable");
  a_zero_run_len: assert property (
    serialOut && !lastOut_r && !serialOutEn_n |-> runCnt_r[3:0] == 4'h0)
    else $error("bit time not whole");
  cover property (rdDone && avsAddress == ADDR_STATUS);
  cover property ($fell(serialOut) && !serialOutEn_n);
  cover property ($rose(txIrq));
endmodule
`default_nettype wire

// file: test/ufat_line_partner.sv
`timescale 1ns/1ps
`default_nettype none
module ufat_line_partner (
  input wire logic        clk_sys,
  input wire logic        lineIn,
  input wire logic        lineOwned_n,
  input wire logic [3:0]  positions,
  input wire logic [15:0] bitClocks,
  output var logic [8:0]  word,
  output var logic        stopOk,
  output var int          frames
);
  // Mid-bit sampling tolerates the one-clock output lag
  initial begin
    word = 9'h0;
    stopOk = 1'b0;
    frames = 0;
    forever begin
      @(negedge lineIn);
      if (!lineOwned_n) begin
        repeat (bitClocks / 2) @(posedge clk_sys);
        if (lineIn == 1'b0) begin
          word = 9'h0;
          for (int k = 0; k < positions; k++) begin
            repeat (bitClocks) @(posedge clk_sys);
            word[k] = lineIn;
          end
          repeat (bitClocks) @(posedge clk_sys);
          stopOk = lineIn;
          frames++;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: test/uart_frame_and_transmitter_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uart_frame_and_transmitter_tb
  import ufat_pkg::*;
;
  logic [ADDR_WIDTH-1:0] avsAddress;
  logic [31:0] avsWriteData, avsReadData;
  logic [3:0]  avsByteEnable, positions;
  logic [15:0] bitClocks;
  logic [8:0]  word;
  logic [7:0]  rdv;
  logic clk_sys, sys_rst, avsRead, avsWrite, avsWaitRequest, stopOk;
  logic serialOut, serialOutEn_n, serialInOwned, txIrq;
  int   frames, base, mismatches = 0, total_checks = 0, cycles = 0;
  logic [7:0] fmtCtl [5] = '{8'h80, 8'ha0, 8'hb8, 8'hc1, 8'he0};
  logic [7:0] fmtDat [5] = '{8'ha5, 8'h07, 8'h07, 8'h3c, 8'h81};
  logic [8:0] fmtExp [5] = '{9'h0a5, 9'h087, 9'h007, 9'h13c, 9'h081};
  logic [7:0] disExp [5] = '{8'h08, 8'h30, 8'hc1, 8'h00, 8'h01};
  ufat_core #(.DIV_WIDTH(8)) i_ufat_core (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .serialOut(serialOut),
    .serialOutEn_n(serialOutEn_n), .serialInOwned(serialInOwned),
    .txIrq(txIrq));
  ufat_line_partner i_ufat_line_partner (.clk_sys(clk_sys),
    .lineIn(serialOut), .lineOwned_n(serialOutEn_n),
    .positions(positions), .bitClocks(bitClocks), .word(word),
    .stopOk(stopOk), .frames(frames));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avsAddress <= a;
    avsWrite <= w;
    avsRead <= !w;
    avsWriteData <= {24'h0, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (avsWaitRequest !== 1'b0 && n < 50);
    rdv = avsReadData[7:0];
    check(n < 50, 1'b1);
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic send(input logic [7:0] d);
    base = frames;
    acc(1'b0, ADDR_STATUS, 8'h0);
    acc(1'b1, ADDR_TX_HOLD, d);
  endtask
  task automatic waitFrame(input logic [8:0] expWord);
    int n;
    n = 0;
    while (frames == base && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    check(frames, base + 1);
    check(word, expWord);
    check(stopOk, 1'b1);
    base = frames;
  endtask
  initial begin
    {sys_rst, avsRead, avsWrite, avsAddress, avsWriteData} = '0;
    sys_rst = 1'b1;
    avsByteEnable = 4'hf;
    positions = 4'h8;
    bitClocks = 16'd64;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      acc(1'b0, 5'(i * 4), 8'h0);
      check(rdv, (i == 2) ? 8'hc1 : 8'h00);
    end
    $display("test reset values done");
    acc(1'b1, ADDR_CTRL_ONE, 8'h80);
    acc(1'b1, ADDR_CTRL_TWO, 8'hd0);
    repeat (2) @(posedge clk_sys);
    check({serialOutEn_n, serialInOwned, serialOut, txIrq}, 4'h7);
    for (int i = 0; i < 5; i++) begin
      acc(1'b1, ADDR_CTRL_ONE, fmtCtl[i]);
      positions <= fmtCtl[i][6] ? 4'h9 : 4'h8;
      send(fmtDat[i]);
      waitFrame(fmtExp[i]);
    end
    $display("test formats done");
    // Let the last stop bit finish so the next write loads directly
    repeat (100) @(posedge clk_sys);
    acc(1'b1, ADDR_CTRL_ONE, 8'h80);
    positions <= 4'h8;
    send(8'h11);
    acc(1'b0, ADDR_STATUS, 8'h0);
    check(rdv, 8'h81);
    acc(1'b1, ADDR_TX_HOLD, 8'h22);
    acc(1'b1, ADDR_TX_HOLD, 8'h33);
    acc(1'b0, ADDR_STATUS, 8'h0);
    check({rdv, txIrq}, 9'h002);
    waitFrame(9'h011);
    waitFrame(9'h022);
    repeat (1200) @(posedge clk_sys);
    check(frames, base);
    acc(1'b0, ADDR_STATUS, 8'h0);
    check(rdv, 8'hc1);
    $display("test back to back done");
    acc(1'b1, ADDR_CTRL_TWO, 8'h50);
    send(8'h5c);
    repeat (300) @(posedge clk_sys);
    check({serialOutEn_n, 8'(frames)}, {1'b1, 8'(base)});
    acc(1'b1, ADDR_CTRL_TWO, 8'hd0);
    waitFrame(9'h05c);
    acc(1'b1, ADDR_BAUD, 8'h01);
    acc(1'b1, ADDR_CTRL_TWO, 8'hf0);
    bitClocks <= 16'd32;
    send(8'h96);
    waitFrame(9'h096);
    $display("test enable and rate done");
    repeat (100) @(posedge clk_sys);
    send(8'h00);
    acc(1'b1, ADDR_TX_HOLD, 8'h55);
    acc(1'b0, ADDR_STATUS, 8'h0);
    check(rdv, 8'h01);
    repeat (100) @(posedge clk_sys);
    acc(1'b1, ADDR_CTRL_ONE, 8'h0c);
    check({serialOutEn_n, serialInOwned}, 2'h2);
    for (int i = 0; i < 5; i++) begin
      acc(1'b0, 5'(i * 4), 8'h0);
      check(rdv, disExp[i]);
    end
    repeat (600) @(posedge clk_sys);
    acc(1'b1, ADDR_CTRL_ONE, 8'h80);
    acc(1'b1, ADDR_CTRL_TWO, 8'hf0);
    base = frames;
    repeat (600) @(posedge clk_sys);
    check(frames, base);
    send(8'h69);
    waitFrame(9'h069);
    send(8'h00);
    repeat (100) @(posedge clk_sys);
    acc(1'b1, ADDR_CTRL_TWO, 8'h60);
    check({serialOutEn_n, txIrq}, 2'h2);
    $display("test disable done");
    print_verdict();
  end
endmodule
bind ufat_core ufat_core_assertions i_ufat_core_assertions (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .avsAddress(avsAddress),
  .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
  .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
  .avsWaitRequest(avsWaitRequest), .serialOut(serialOut),
  .serialOutEn_n(serialOutEn_n), .serialInOwned(serialInOwned),
  .txIrq(txIrq));
`default_nettype wire
